// ---- hdl/abws_consts.svh ----
/*
 * constants of the external bus write / locked read sequencer:
 * widths, masks, idle pin values and buffer depth.
 * assumes inclusion by bare name from the package and the sequencer module.
 */
`ifndef ABWS_CONSTS_SVH
`define ABWS_CONSTS_SVH

// --------------------------------------------------------------
// widths
// --------------------------------------------------------------
`define ABWS_ADDR_W 32
`define ABWS_DATA_W 32
`define ABWS_SPACE_W 3
`define ABWS_SIZE_W 2

// --------------------------------------------------------------
// masks and idle values
// --------------------------------------------------------------
`define ABWS_FULL_MASK 32'hffffffff
`define ABWS_REDUCED_MASK 32'h00ffffff
`define ABWS_ACK_NONE 2'h3
`define ABWS_NEGATED 1'h1

// --------------------------------------------------------------
// buffering
// --------------------------------------------------------------
`define ABWS_FIFO_DEPTH 8

`endif

// ---- hdl/abws_pkg.sv ----
/*
 * types of the external bus write / locked read sequencer.
 * assumes the constants header is on the include path.
 */
`include "abws_consts.svh"

package abws_pkg;

    // ----------------------------------------------------------
    // commands
    // ----------------------------------------------------------
    typedef enum logic [1:0]
    {
        ABWS_TAS = 2'h0,
        ABWS_CAS = 2'h1,
        ABWS_DUAL_COMPARE_SWAP_INSTR = 2'h2
    } abws_instr_t;

    typedef struct packed
    {
        logic isRmw;
        abws_instr_t instr;
        logic first;
        logic [`ABWS_SPACE_W-1:0] space;
        logic [`ABWS_SIZE_W-1:0] size;
        logic [`ABWS_ADDR_W-1:0] addr;
        logic [`ABWS_DATA_W-1:0] data;
    } abws_cmd_t;

    // ----------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------
    typedef enum logic [8:0]
    {
        ABWS_IDLE = 9'h001,
        ABWS_S0 = 9'h002,
        ABWS_S1 = 9'h004,
        ABWS_S2 = 9'h008,
        ABWS_S3 = 9'h010,
        ABWS_WAIT = 9'h020,
        ABWS_S4 = 9'h040,
        ABWS_S5 = 9'h080,
        ABWS_MODIFY = 9'h100
    } abws_state_t;

    typedef struct packed
    {
        abws_state_t st;
        logic isRmw;
        logic isWrite;
        abws_instr_t instr;
        logic first;
        logic ackSeen;
        logic [`ABWS_SPACE_W-1:0] space;
        logic [`ABWS_SIZE_W-1:0] size;
        logic [`ABWS_ADDR_W-1:0] addr;
        logic [`ABWS_DATA_W-1:0] data;
        logic [`ABWS_DATA_W-1:0] rdData;
        logic rnw;
        logic ecsN;
        logic ocsN;
        logic asN;
        logic dsN;
        logic dbenN;
        logic dataOe;
        logic lockedN;
        logic grantN;
    } abws_seq_st_t;

endpackage

// ---- hdl/abws_fifo.sv ----
/*
 * command buffer: valid/ready on both sides, width and depth
 * parameters. assumes one clock and an asynchronous high reset.
 */
`timescale 1ns/10ps

module abws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } abws_fifo_st_t;

    abws_fifo_st_t q;
    abws_fifo_st_t d;
    logic push;
    logic pop;

    assign inReady = (q.cnt != (AW+1)'(DEPTH));
    assign outValid = (q.cnt != '0);
    assign outData = q.mem[q.rd];
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    // pointers wrap explicitly so a depth that is not a power of two works
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wr] = inData;
            d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
        end
        if (push & !pop)
        begin
            d.cnt = q.cnt + 1'b1;
        end
        else if (pop & !push)
        begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule

// ---- hdl/abws_sequencer.sv ----
/*
 * processor-side external bus sequencer: write cycles and the
 * read, modify wait and write of locked read-modify-write cycles.
 * each clk edge is one bus state (half bus clock); ack is sampled
 * synchronously, the bench keeps it stable around sampling edges.
 */
`timescale 1ns/10ps
`include "abws_consts.svh"

module abws_sequencer #(
    parameter bit REDUCED_ADDR = 1'b0,
    parameter int FIFO_DEPTH = `ABWS_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdIsRmw,
    input wire abws_pkg::abws_instr_t cmdInstr,
    input wire logic cmdFirst,
    input wire logic [`ABWS_SPACE_W-1:0] cmdSpace,
    input wire logic [`ABWS_SIZE_W-1:0] cmdSize,
    input wire logic [`ABWS_ADDR_W-1:0] cmdAddr,
    input wire logic [`ABWS_DATA_W-1:0] cmdData,
    output logic readValid,
    output logic [`ABWS_DATA_W-1:0] readData,
    input wire logic modifyValid,
    input wire logic modifyWrite,
    input wire logic [`ABWS_DATA_W-1:0] modifyData,
    output logic [`ABWS_ADDR_W-1:0] addrOut,
    output logic [`ABWS_SPACE_W-1:0] spaceCode,
    output logic [`ABWS_SIZE_W-1:0] transferSize,
    output logic readNotWrite,
    output logic externalCycleStartN,
    output logic operandCycleStartN,
    output logic addressStrobeN,
    output logic dataStrobeN,
    output logic bufferEnableN,
    output logic [`ABWS_DATA_W-1:0] dataOut,
    output logic dataOe,
    input wire logic [`ABWS_DATA_W-1:0] dataIn,
    input wire logic [1:0] portAckN,
    output logic lockedCycleN,
    input wire logic busRequestN,
    output logic busGrantN
);
    import abws_pkg::*;

    localparam logic [`ABWS_ADDR_W-1:0] ADDR_MASK =
        REDUCED_ADDR ? `ABWS_REDUCED_MASK : `ABWS_FULL_MASK;

    localparam abws_seq_st_t ST_RST = '{
        st: ABWS_IDLE,
        instr: ABWS_TAS,
        rnw: `ABWS_NEGATED,
        ecsN: `ABWS_NEGATED,
        ocsN: `ABWS_NEGATED,
        asN: `ABWS_NEGATED,
        dsN: `ABWS_NEGATED,
        dbenN: `ABWS_NEGATED,
        lockedN: `ABWS_NEGATED,
        grantN: `ABWS_NEGATED,
        default: '0
    };

    abws_seq_st_t q;
    abws_seq_st_t d;
    abws_cmd_t cmdIn;
    abws_cmd_t cmdHead;
    logic headValid;
    logic popCmd;
    logic ackHit;

    // --------------------------------------------------------------
    // command buffer
    // --------------------------------------------------------------
    assign cmdIn = '{
        isRmw: cmdIsRmw,
        instr: cmdInstr,
        first: cmdFirst,
        space: cmdSpace,
        size: cmdSize,
        addr: cmdAddr,
        data: cmdData
    };

    abws_fifo #(
        .WIDTH($bits(abws_cmd_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(cmdValid),
        .inReady(cmdReady),
        .inData(cmdIn),
        .outValid(headValid),
        .outReady(popCmd),
        .outData(cmdHead)
    );

    // either ack line low counts as recognised
    assign ackHit = (portAckN != `ABWS_ACK_NONE);

    // --------------------------------------------------------------
    // sequencing
    // --------------------------------------------------------------
    always_comb
    begin
        d = q;
        popCmd = 1'b0;
        case (q.st)
            ABWS_IDLE:
            begin
                d.isRmw = 1'b0;
                d.isWrite = 1'b0;
                // grant only decided here, so never during a lock
                if (!busRequestN)
                begin
                    d.grantN = 1'b0;
                end
                else
                begin
                    d.grantN = 1'b1;
                    if (q.grantN && headValid)
                    begin
                        popCmd = 1'b1;
                        // atomic commands lock, plain ones write
                        d.isRmw = cmdHead.isRmw;
                        d.isWrite = !cmdHead.isRmw;
                        d.instr = cmdHead.instr;
                        d.first = cmdHead.first | cmdHead.isRmw;
                        d.space = cmdHead.space;
                        d.size = cmdHead.size;
                        d.addr = cmdHead.addr & ADDR_MASK;
                        d.data = cmdHead.data;
                        d.st = ABWS_S0;
                    end
                end
            end
            ABWS_S0:
            begin
                d.st = ABWS_S1;
            end
            ABWS_S1:
            begin
                d.st = ABWS_S2;
            end
            ABWS_S2:
            begin
                d.ackSeen = ackHit;
                d.st = ABWS_S3;
            end
            ABWS_S3:
            begin
                d.st = q.ackSeen ? ABWS_S4 : ABWS_WAIT;
            end
            ABWS_WAIT:
            begin
                if (ackHit)
                begin
                    d.st = ABWS_S4;
                end
            end
            ABWS_S4:
            begin
                if (!q.isWrite)
                begin
                    d.rdData = dataIn;
                end
                d.st = ABWS_S5;
            end
            ABWS_S5:
            begin
                if (q.isRmw && !q.isWrite)
                begin
                    d.st = ABWS_MODIFY;
                end
                else
                begin
                    d.isRmw = 1'b0;
                    d.st = ABWS_IDLE;
                end
            end
            ABWS_MODIFY:
            begin
                if (modifyValid)
                begin
                    // test-and-set always writes back
                    if (modifyWrite || q.instr == ABWS_TAS)
                    begin
                        d.isWrite = 1'b1;
                        d.first = 1'b1;
                        d.data = modifyData;
                        d.st = ABWS_S0;
                    end
                    else
                    begin
                        // skipped write drops the lock and returns straight to idle
                        d.isRmw = 1'b0;
                        d.st = ABWS_IDLE;
                    end
                end
            end
            default:
            begin
                d = ST_RST;
            end
        endcase
        // pins decoded from the next state so they are registered
        d.ecsN = REDUCED_ADDR | (d.st != ABWS_S0);
        d.ocsN = REDUCED_ADDR | (d.st != ABWS_S0) | !d.first;
        d.asN = !(d.st inside {ABWS_S1, ABWS_S2, ABWS_S3, ABWS_WAIT,
            ABWS_S4});
        d.dsN = d.isWrite ?
            !(d.st inside {ABWS_S3, ABWS_WAIT, ABWS_S4}) :
            !(d.st inside {ABWS_S1, ABWS_S2, ABWS_S3, ABWS_WAIT, ABWS_S4});
        d.dbenN = REDUCED_ADDR | (d.isWrite ?
            !(d.st inside {ABWS_S1, ABWS_S2, ABWS_S3, ABWS_WAIT, ABWS_S4,
            ABWS_S5}) :
            !(d.st inside {ABWS_S2, ABWS_S3, ABWS_WAIT, ABWS_S4}));
        d.dataOe = d.isWrite & (d.st inside {ABWS_S2, ABWS_S3, ABWS_WAIT,
            ABWS_S4, ABWS_S5});
        d.rnw = !(d.isWrite & (d.st inside {ABWS_S0, ABWS_S1, ABWS_S2,
            ABWS_S3, ABWS_WAIT, ABWS_S4, ABWS_S5}));
        d.lockedN = !d.isRmw;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign readValid = (q.st == ABWS_MODIFY);
    assign readData = q.rdData;
    assign addrOut = q.addr;
    assign spaceCode = q.space;
    assign transferSize = q.size;
    assign readNotWrite = q.rnw;
    assign externalCycleStartN = q.ecsN;
    assign operandCycleStartN = q.ocsN;
    assign addressStrobeN = q.asN;
    assign dataStrobeN = q.dsN;
    assign bufferEnableN = q.dbenN;
    assign dataOut = q.data;
    assign dataOe = q.dataOe;
    assign lockedCycleN = q.lockedN;
    assign busGrantN = q.grantN;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_cycle_start_s0: assert property (
        !q.ecsN |-> q.st == ABWS_S0 && !REDUCED_ADDR)
        else $error("cycle start outside S0");

    a_write_s0_drive: assert property (
        q.st == ABWS_S0 && q.isWrite |-> !q.rnw
            && (q.ecsN == REDUCED_ADDR) ##1 !q.asN && q.ecsN && q.ocsN)
        else $error("write S0/S1 pins wrong");

    a_ack_no_wait: assert property (
        q.st == ABWS_S2 && ackHit |=> q.st == ABWS_S3
            ##1 q.st == ABWS_S4 ##1 q.st == ABWS_S5 && q.asN && q.dsN)
        else $error("acked cycle did not end one clock later");

    a_wait_holds: assert property (
        q.st == ABWS_WAIT && !ackHit |=> q.st == ABWS_WAIT && !q.asN)
        else $error("wait state left without ack");

    a_s4_no_change: assert property (
        q.st == ABWS_S4 && q.isWrite |-> $stable({q.asN, q.dsN, q.dbenN,
            q.rnw, q.dataOe, q.lockedN}))
        else $error("control changed in write S4");

    a_s5_hold: assert property (
        q.st == ABWS_S5 && q.isWrite |-> q.asN && q.dsN && q.dataOe
            && !q.rnw && $stable(q.addr) && $stable(q.data)
            && (q.dbenN == REDUCED_ADDR))
        else $error("write S5 hold broken");

    a_locked_held: assert property (
        !q.lockedN && q.st != ABWS_MODIFY && !(q.st == ABWS_S5 && q.isWrite)
            |=> !q.lockedN)
        else $error("lock dropped inside sequence");

    a_no_grant_lock: assert property (
        !q.lockedN |-> q.grantN)
        else $error("grant during locked sequence");

    a_rmw_s0_pins: assert property (
        q.st == ABWS_S0 && q.isRmw && !q.isWrite |-> q.rnw && !q.lockedN
            && (q.ocsN == REDUCED_ADDR) ##1 !q.asN && !q.dsN
            ##1 q.dbenN == REDUCED_ADDR)
        else $error("locked read S0..S2 pins wrong");

    a_read_latch: assert property (
        q.st == ABWS_S4 && !q.isWrite |=> q.rdData == $past(dataIn))
        else $error("read data not latched");

    a_modify_quiet: assert property (
        q.st == ABWS_MODIFY |-> q.rnw && !q.dataOe && !q.lockedN)
        else $error("bus driven while modifying");

    a_write_data_s2: assert property (
        q.st == ABWS_S1 && q.isWrite |=> q.dataOe && q.dsN)
        else $error("write data not driven in S2");

    c_write_fast: cover property (
        q.st == ABWS_S2 && q.isWrite && ackHit ##3 q.st == ABWS_IDLE);
    c_write_wait: cover property (
        q.st == ABWS_WAIT && q.isWrite ##1 q.st == ABWS_WAIT);
    c_rmw_write: cover property (
        q.st == ABWS_MODIFY ##1 q.st == ABWS_S0 && q.isWrite);
    c_rmw_skip: cover property (
        q.st == ABWS_MODIFY && q.isRmw ##1 q.st == ABWS_IDLE);

endmodule

// ---- verification/abws_mem_model.sv ----
/*
 * far-side model: an external memory port that answers the
 * sequencer's write and locked read cycles with set ack delays.
 * assumes one clock, async high reset, bench-set delay and pattern.
 */
`timescale 1ns/10ps

module abws_mem_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic addressStrobeN,
    input wire logic dataStrobeN,
    input wire logic readNotWrite,
    input wire logic dataOe,
    input wire logic [31:0] dataOut,
    input var int ackDelay,
    input wire logic [1:0] transferSize,
    input wire logic [1:0] addrLow,
    input wire logic [1:0] ackPat,
    input wire logic [31:0] readWord,
    output logic [31:0] dataIn,
    output logic [1:0] portAckN,
    output logic wrPulse,
    output logic [31:0] wrData
);
    int cnt;
    logic taken;
    logic [31:0] lastDrv;

    // byte lanes of a 32-bit port picked by size and low address bits
    function automatic logic [31:0] laneMask(input logic [1:0] sz,
                                             input logic [1:0] off);
        int n;
        laneMask = '0;
        n = (sz == 2'h0) ? 4 : int'(sz);
        for (int j = 0; j < 4; j++)
            if (j >= off && j < off + n)
                laneMask[31 - 8 * j -: 8] = 8'hff;
    endfunction

    // ----------------------------------------------------------
    // data lines
    // ----------------------------------------------------------
    // unselected lines show the inverse, never a stale word
    assign dataIn = (!addressStrobeN && readNotWrite) ? readWord
        : ~lastDrv;

    // ----------------------------------------------------------
    // acknowledge and capture
    // ----------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            taken <= 1'b0;
            lastDrv <= 32'h0;
            portAckN <= 2'h3;
            wrPulse <= 1'b0;
            wrData <= 32'h0;
        end
        else
        begin
            wrPulse <= 1'b0;
            if (!addressStrobeN && readNotWrite)
            begin
                lastDrv <= readWord;
            end
            if (addressStrobeN)
            begin
                cnt <= 0;
                taken <= 1'b0;
                portAckN <= 2'h3;
            end
            else
            begin
                cnt <= cnt + 1;
                // both lines stay high while waits are wanted
                if (cnt >= ackDelay)
                begin
                    portAckN <= ackPat;
                end
                if (!dataStrobeN && !readNotWrite && dataOe && !taken)
                begin
                    taken <= 1'b1;
                    wrPulse <= 1'b1;
                    wrData <= dataOut & laneMask(transferSize, addrLow);
                end
            end
        end
    end
endmodule

// ---- verification/abws_sequencer_tb_top.sv ----
/*
 * self-checking bench of the bus sequencer: writes with waits,
 * locked sequences of each form, grant holding, buffer fill.
 * assumes the memory model and the design files compiled first.
 */
`timescale 1ns/10ps

module abws_sequencer_tb_top;
    import abws_pkg::*;
    logic clk, rst, cmdValid, cmdReady, cmdIsRmw, cmdFirst;
    abws_instr_t cmdInstr;
    logic [2:0] cmdSpace, spaceCode, cSpace;
    logic [1:0] cmdSize, transferSize, cSize, portAckN, ackPat;
    logic [31:0] cmdAddr, cmdData, readData, modifyData, addrOut;
    logic [31:0] dataOut, dataIn, readWord, wrData, a, d, md;
    logic readValid, modifyValid, modifyWrite, readNotWrite, dataOe;
    logic externalCycleStartN, operandCycleStartN, addressStrobeN;
    logic dataStrobeN, bufferEnableN, lockedCycleN, busRequestN;
    logic busGrantN, wrPulse, f, want, full;
    int fails, compares, cycles, ackDelay, seed, i, n;
    int dly[4] = '{0, 1, 2, 5};
    logic [1:0] pat[4] = '{2'h2, 2'h1, 2'h0, 2'h2};
    logic [31:0] expWr[$], gotWr[$];

    abws_sequencer abws_sequencer_i (.clk, .rst, .cmdValid, .cmdReady,
        .cmdIsRmw, .cmdInstr, .cmdFirst, .cmdSpace, .cmdSize, .cmdAddr,
        .cmdData, .readValid, .readData, .modifyValid, .modifyWrite,
        .modifyData, .addrOut, .spaceCode, .transferSize, .readNotWrite,
        .externalCycleStartN, .operandCycleStartN, .addressStrobeN,
        .dataStrobeN, .bufferEnableN, .dataOut, .dataOe, .dataIn,
        .portAckN, .lockedCycleN, .busRequestN, .busGrantN);

    abws_mem_model abws_mem_model_i (.clk, .rst, .addressStrobeN,
        .dataStrobeN, .readNotWrite, .dataOe, .dataOut, .ackDelay,
        .transferSize, .addrLow(addrOut[1:0]),
        .ackPat, .readWord, .dataIn, .portAckN, .wrPulse, .wrData);

    // ----------------------------------------------------------
    // clock, watchdog, helpers
    // ----------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (wrPulse)
            gotWr.push_back(wrData);
        // generous: the whole run needs about 240 cycles
        if (cycles == 20000)
        begin
            fails++;
            stop_test;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // byte lanes of a 32-bit port picked by size and low address bits
    function automatic logic [31:0] laneMask(input logic [1:0] sz,
                                             input logic [1:0] off);
        int n;
        laneMask = '0;
        n = (sz == 2'h0) ? 4 : int'(sz);
        for (int j = 0; j < 4; j++)
            if (j >= off && j < off + n)
                laneMask[31 - 8 * j -: 8] = 8'hff;
    endfunction

    task tick;
        @(posedge clk);
        #1;
    endtask

    task stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task push(input logic rmw, input int ins, input logic fst,
              input logic [31:0] ad, input logic [31:0] dd);
        int k;
        @(negedge clk);
        cSpace = 3'($random(seed));
        cSize = 2'($random(seed));
        cmdValid = 1'b1;
        cmdIsRmw = rmw;
        cmdInstr = abws_instr_t'(ins[1:0]);
        cmdFirst = fst;
        cmdSpace = cSpace;
        cmdSize = cSize;
        cmdAddr = ad;
        cmdData = dd;
        k = 0;
        while (cmdReady !== 1'b1 && k < 100)
        begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        cmdValid = 1'b0;
    endtask

    // walks one bus cycle from S0 to S5 and checks S0 to S3 and S5
    task busCheck(input logic rd, input logic lk, input logic fst,
                  input logic [31:0] ad, input logic [31:0] dd,
                  input int w);
        int k;
        k = 0;
        while (externalCycleStartN !== 1'b0 && k < 200)
        begin
            tick;
            k++;
        end
        check(readNotWrite, rd);
        check(addrOut, ad);
        check({spaceCode, transferSize}, {cSpace, cSize});
        check(operandCycleStartN, !fst);
        check(lockedCycleN, !lk);
        tick;
        check({addressStrobeN, externalCycleStartN, operandCycleStartN},
              3'h3);
        check({dataStrobeN, bufferEnableN}, {!rd, rd});
        tick;
        check({dataOe, bufferEnableN}, {!rd, 1'b0});
        if (!rd)
            check(dataOut, dd);
        tick;
        check(dataStrobeN, 1'b0);
        k = 0;
        while (addressStrobeN === 1'b0 && k < 200)
        begin
            tick;
            k++;
        end
        // S3 itself never samples, so one late ack costs one wait
        check(k, ((w < 2) ? w : w - 1) + 2);
        check({dataStrobeN, bufferEnableN, readNotWrite},
              {1'b1, rd, rd});
        check(addrOut, ad);
        if (!rd)
            check(dataOut, dd);
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        seed = 32'hf064cac2;
        {cmdValid, cmdIsRmw, cmdFirst, modifyValid, modifyWrite} = 5'h0;
        cmdInstr = ABWS_TAS;
        {cmdSpace, cmdSize, cmdAddr, cmdData, modifyData} = '0;
        busRequestN = 1'b1;
        readWord = 32'h0;
        ackDelay = 0;
        ackPat = 2'h2;
        rst = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        tick;
        check({cmdReady, readValid, addressStrobeN, readNotWrite,
               lockedCycleN, dataOe}, 6'h2e);
        for (i = 0; i < 4; i++)
        begin
            ackDelay = dly[i];
            ackPat = pat[i];
            a = $random(seed);
            d = $random(seed);
            f = i[0];
            push(1'b0, 0, f, a, d);
            expWr.push_back(d & laneMask(cSize, a[1:0]));
            busCheck(1'b0, 1'b0, f, a, d, ackDelay);
        end
        $display("test plain writes done");
        for (i = 0; i < 6; i++)
        begin
            ackDelay = i % 3;
            a = $random(seed);
            d = $random(seed);
            md = $random(seed);
            readWord = $random(seed);
            push(1'b1, i % 3, 1'b1, a, d);
            busCheck(1'b1, 1'b1, 1'b1, a, d, ackDelay);
            n = 0;
            while (readValid !== 1'b1 && n < 20)
            begin
                tick;
                n++;
            end
            check(readData, readWord);
            @(negedge clk);
            busRequestN = 1'b0;
            repeat (3) tick;
            check({lockedCycleN, busGrantN, readNotWrite, dataOe},
                  4'h6);
            @(negedge clk);
            modifyValid = 1'b1;
            modifyWrite = (i < 3);
            modifyData = md;
            want = (i % 3 == 0) || (i < 3);
            @(negedge clk);
            modifyValid = 1'b0;
            if (want)
            begin
                expWr.push_back(md & laneMask(cSize, a[1:0]));
                busCheck(1'b0, 1'b1, 1'b1, a, md, ackDelay);
            end
            n = 0;
            while (busGrantN !== 1'b0 && n < 20)
            begin
                tick;
                n++;
            end
            check({lockedCycleN, busGrantN}, 2'h2);
            check(gotWr.size(), expWr.size());
            @(negedge clk);
            busRequestN = 1'b1;
            repeat (3) tick;
        end
        $display("test locked sequences done");
        ackDelay = 30;
        full = 1'b0;
        cmdFirst = 1'b0;
        cmdIsRmw = 1'b0;
        for (i = 0; i < 12 && !full; i++)
        begin
            @(negedge clk);
            if (cmdReady !== 1'b1)
            begin
                full = 1'b1;
                cmdValid = 1'b0;
            end
            else
            begin
                d = $random(seed);
                cmdAddr = $random(seed);
                cmdData = d;
                cmdValid = 1'b1;
                expWr.push_back(d & laneMask(cSize, cmdAddr[1:0]));
            end
        end
        if (!full)
        begin
            @(negedge clk);
            cmdValid = 1'b0;
        end
        check(full, 1'b1);
        ackDelay = 0;
        n = 0;
        while (gotWr.size() < expWr.size() && n < 3000)
        begin
            tick;
            n++;
        end
        check(gotWr.size(), expWr.size());
        foreach (expWr[k])
            check(gotWr[k], expWr[k]);
        $display("test buffer fill done");
        stop_test;
    end
endmodule
